// ==== bench/psdp_ctrl_model.sv ====
// Controller side model: delayed write data and the shared bus level
module psdp_ctrl_model
  import psdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic cycle_qualify_n,
  input wire logic wr_cmd,
  input wire logic [35:0] wr_word,
  input wire logic [35:0] dev_word,
  input wire logic dev_oe,
  output logic [35:0] bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] v_q = 2'h0;
  logic [35:0] w1_q = 36'h0;
  logic [35:0] w2_q = 36'h0;
  logic [35:0] last_q = 36'h0;
  always @(posedge core_clk) begin
    if (!cycle_qualify_n) begin
      v_q <= {v_q[0], wr_cmd};
      w1_q <= wr_word;
      w2_q <= w1_q;
    end
    last_q <= bus;
  end
  // Released bus toggles so a stale value never passes
  always_comb bus = v_q[1] ? w2_q : (dev_oe ? dev_word : ~last_q);
endmodule : psdp_ctrl_model

// ==== bench/testbench.sv ====
// Self-checking bench of the pipelined SRAM data port
module testbench
  import psdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_b = 0, qn = 0, allow_n = 0, order = 1, wr = 0, qual_seen = 0;
  psdp_cmd_type cmd = '0;
  logic [35:0] wword = '0, bus, mem [int], expq [$];
  logic [31:0] dout;
  logic [3:0] pout;
  logic oe, poe;
  logic [18:0] ba = '0;
  logic [1:0] bc = '0;
  int num_errors = 0, n_checks = 0;
  always #10 core_clk = ~core_clk;
  psdp_port u_dut (.core_clk(core_clk), .rst_b(rst_b), .cycle_qualify_n(qn), .cmd(cmd),
    .out_allow_n(allow_n), .burst_order(order), .data_in(bus[31:0]), .data_out(dout),
    .data_oe(oe), .parity_lines_in(bus[35:32]), .parity_lines_out(pout),
    .parity_lines_oe(poe));
  psdp_ctrl_model u_ctrl (.core_clk(core_clk), .cycle_qualify_n(qn), .wr_cmd(wr),
    .wr_word(wword), .dev_word({pout, dout}), .dev_oe(oe), .bus(bus));
  task check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task op(input bit rd, input bit adv, input logic [18:0] a, input logic [3:0] lane_n,
          input bit sel);
    logic [35:0] w;
    logic [18:0] ra;
    w = 36'({$urandom, $urandom});
    while ($urandom % 4 == 0) begin
      qn = 1;
      @(negedge core_clk);
    end
    if (!adv) begin
      ba = a;
      bc = 0;
    end else bc++;
    ra = {ba[18:2], order ? ba[1:0] ^ bc : ba[1:0] + bc};
    qn = 0;
    cmd = '{1'b0, sel, 1'b0, rd, adv, a, lane_n};
    wr = sel && !rd;
    wword = w;
    for (int i = 0; i < 4; i++) if (wr && !lane_n[i]) begin
      mem[ra][8*i+:8] = w[8*i+:8];
      mem[ra][32+i] = w[32+i];
    end
    if (sel && rd && !allow_n) expq.push_back(mem[ra]);
    @(negedge core_clk);
  endtask : op
  // Every qualified edge with drive on must carry the next read result
  always @(posedge core_clk) qual_seen <= rst_b && !qn;
  always @(negedge core_clk) if (qual_seen) begin
    check(oe & u_ctrl.v_q[1], 0);
    check(poe, oe);
    if (oe === 1'b1) begin
      if (expq.size() == 0) check(1, 0);
      else check({pout, dout}, expq.pop_front());
    end
  end
  initial begin
    bit lrd, lsel;
    void'($urandom(13));
    for (int ph = 0; ph < 2; ph++) begin
      order = !ph; // Strap changes only under reset
      rst_b = 0;
      repeat (3) @(negedge core_clk);
      rst_b = 1;
      for (int i = 0; i < 16; i++) op(0, 0, 19'(i), 4'h0, 1);
      // A burst right after the fill continues the last write
      lrd = 0;
      lsel = 1;
      repeat (80) begin
        case ($urandom % 4)
          0: op(lrd, 1, 19'h0, 4'($urandom), lsel);
          1: op(1, 0, 19'($urandom % 16), 4'hF, 1);
          2: op(0, 0, 19'($urandom % 16), 4'($urandom), 1);
          default: op(1, 0, 19'h0, 4'hF, 0);
        endcase
        lrd = cmd.write_enable_n;
        lsel = cmd.select_two;
      end
      repeat (4) op(1, 0, 19'h0, 4'hF, 0);
      allow_n = 1;
      repeat (4) op(1, 0, 19'h0, 4'hF, 0);
      repeat (4) op(1, 0, 19'($urandom % 16), 4'hF, 1);
      // Allow only after the unrecorded reads have left the output register
      repeat (4) op(1, 0, 19'h0, 4'hF, 0);
      allow_n = 0;
    end
    check(expq.size(), 0);
    stop_test();
  end
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule : testbench

// ==== hdl/psdp_port.sv ====
// Data port of a synchronous pipelined burst SRAM with byte lanes and parity
// Function
// [RL1] Drive data and parity when allowed
// [RL2] Allow input high floats data and parity
// [RL3] Float during writes, after deselect, deselected
// [RL4] Act only on qualified rising edges; the allow and strap synchronisers and both enables update on every edge
// [RL5] Unqualified edge keeps whole state, selection too; the allow and strap synchronisers and both enables still move
// [RL6] Data lines captured on rising edge
// [RL7] Read data from address sampled before
// [RL8] Parity behaves as data, per lane select
// [RL9] Strap high interleaved, low linear burst
// [RL10] Open strap reads high; keep it constant
// [RL11] Lane selects with write strobe, per lane
// [RL12] Read data out next qualified edge
// [RL13] Write floats next edge, data following edge
// [RL14] Deselect floats outputs after next edge
// [RL15] Enable is permission AND inverted allow
`include "psdp_consts.svh"
module psdp_port
  import psdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cycle_qualify_n,
  input wire psdp_cmd_type cmd,
  input wire logic out_allow_n,
  input wire logic burst_order,
  input wire logic [`PSDP_DATA_W-1:0] data_in,
  output logic [`PSDP_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [`PSDP_LANES-1:0] parity_lines_in,
  output logic [`PSDP_LANES-1:0] parity_lines_out,
  output logic parity_lines_oe
);

  psdp_state_type s_q;
  psdp_state_type s_d;
  logic qual;
  logic selected;
  logic [1:0] cnt_next;
  logic [`PSDP_LANES-1:0][`PSDP_LANE_W-1:0] rd_word;

  assign qual = ~cycle_qualify_n; // [RL4]
  assign selected = ~cmd.select_one_n & cmd.select_two & ~cmd.select_three_n;
  assign cnt_next = s_q.a_cnt + 2'h1;

  // One array per byte lane, so each lane write has its own single driver
  for (genvar i = 0; i < `PSDP_LANES; i++) begin : g_lane
    logic [`PSDP_LANE_W-1:0] lane_mem [0:`PSDP_DEPTH-1];
    logic fwd;
    // Write landing on the read edge is forwarded, else the read is stale
    assign fwd = s_q.b_valid & ~s_q.b_lane_wr_n[i] & (s_q.b_addr == s_q.a_addr);
    assign rd_word[i] = fwd ? {parity_lines_in[i], data_in[i*`PSDP_BYTE_W +: `PSDP_BYTE_W]}
                            : lane_mem[s_q.a_addr]; // [RL7]
    always_ff @(posedge core_clk) begin
      // Data lines sampled at the second qualified edge after the write command; parity as a ninth bit
      if (rst_b && qual && s_q.b_valid && !s_q.b_lane_wr_n[i]) begin // [RL6] [RL8] [RL11] [RL13]
        lane_mem[s_q.b_addr] <= {parity_lines_in[i],
                                 data_in[i*`PSDP_BYTE_W +: `PSDP_BYTE_W]};
      end
    end

    // Per lane, so a swapped byte or parity bit shows up
    property p_lane_read;
      @(posedge core_clk) disable iff (!rst_b)
      (qual && s_q.a_valid && !s_q.a_write)
        |=> {parity_lines_out[i], data_out[i*`PSDP_BYTE_W +: `PSDP_BYTE_W]}
            == $past(rd_word[i]);
    endproperty
    a_lane_read: assert property (p_lane_read) // [RL7] [RL8]
      else $error("lane read data not from latched address");

    property p_lane_write;
      @(posedge core_clk) disable iff (!rst_b)
      (qual && !cmd.advance_or_load && selected && !cmd.write_enable_n &&
       !cmd.lane_write_select_n[i]) ##1 qual ##1 qual
        |=> lane_mem[$past(s_q.b_addr)] ==
            $past({parity_lines_in[i], data_in[i*`PSDP_BYTE_W +: `PSDP_BYTE_W]});
    endproperty
    a_lane_write: assert property (p_lane_write) // [RL6] [RL11] [RL13]
      else $error("selected lane not written from data lines");
  end

  always_comb begin
    s_d = s_q;
    // Allow input and strap come from pins, so each passes two flip-flops
    s_d.allow_s1 = out_allow_n;
    s_d.allow_s2 = s_q.allow_s1;
    s_d.order_s1 = burst_order; // [RL10]
    s_d.order_s2 = s_q.order_s1;
    if (qual) begin // [RL4] [RL5]
      s_d.b_valid = s_q.a_valid & s_q.a_write;
      s_d.b_addr = s_q.a_addr;
      s_d.b_lane_wr_n = s_q.a_lane_wr_n;
      // Writes and deselects both drop permission at the next edge
      s_d.drive_perm = s_q.a_valid & ~s_q.a_write; // [RL3] [RL12] [RL13] [RL14]
      if (s_d.drive_perm) begin // [RL12]
        for (int i = 0; i < `PSDP_LANES; i++) begin
          s_d.dout[i*`PSDP_BYTE_W +: `PSDP_BYTE_W] = rd_word[i][`PSDP_BYTE_W-1:0];
          s_d.pout[i] = rd_word[i][`PSDP_BYTE_W]; // [RL8]
        end
      end
      s_d.a_lane_wr_n = cmd.lane_write_select_n; // [RL11]
      if (cmd.advance_or_load) begin
        // Burst step ignores chip selects, takes new lane selects and keeps the latched access type
        s_d.a_cnt = cnt_next;
        s_d.a_addr[1:0] = s_q.order_s2 ? (s_q.a_base ^ cnt_next)
                                       : (s_q.a_base + cnt_next); // [RL9]
      end else begin
        s_d.a_valid = selected;
        s_d.a_write = ~cmd.write_enable_n;
        s_d.a_addr = cmd.addr;
        s_d.a_base = cmd.addr[1:0];
        s_d.a_cnt = 2'h0;
      end
    end
    // Allow input is sampled twice, so the enable follows it on the third edge, not at once as through a pure gate
    s_d.data_oe = s_d.drive_perm & ~s_q.allow_s2; // [RL1] [RL2] [RL15]
    s_d.parity_oe = s_d.drive_perm & ~s_q.allow_s2; // [RL8]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.allow_s1 <= `PSDP_RST_ALLOW_N;
      s_q.allow_s2 <= `PSDP_RST_ALLOW_N;
      s_q.order_s1 <= `PSDP_RST_ORDER;
      s_q.order_s2 <= `PSDP_RST_ORDER;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.dout;
  assign data_oe = s_q.data_oe;
  assign parity_lines_out = s_q.pout;
  assign parity_lines_oe = s_q.parity_oe;

  property p_hold_unqualified;
    @(posedge core_clk) disable iff (!rst_b)
    cycle_qualify_n |=> $stable(s_q.a_addr) && $stable(s_q.a_valid) &&
                        $stable(s_q.drive_perm) && $stable(s_q.b_valid);
  endproperty
  a_hold_unqualified: assert property (p_hold_unqualified) // [RL5]
    else $error("state moved on an unqualified edge");

  property p_read_drives;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !cmd.advance_or_load && selected && cmd.write_enable_n) ##1 qual
      |=> s_q.drive_perm;
  endproperty
  a_read_drives: assert property (p_read_drives) // [RL12]
    else $error("read did not gain drive permission");

  property p_allow_high_floats;
    @(posedge core_clk) disable iff (!rst_b)
    s_q.allow_s2 |=> !data_oe && !parity_lines_oe;
  endproperty
  a_allow_high_floats: assert property (p_allow_high_floats) // [RL2]
    else $error("driving while allow input high");

  property p_enable_cause;
    @(posedge core_clk) disable iff (!rst_b)
    data_oe |-> s_q.drive_perm && !$past(s_q.allow_s2);
  endproperty
  a_enable_cause: assert property (p_enable_cause) // [RL15]
    else $error("enable without permission and allow");

  property p_parity_follows;
    @(posedge core_clk) disable iff (!rst_b)
    parity_lines_oe == data_oe;
  endproperty
  a_parity_follows: assert property (p_parity_follows) // [RL8]
    else $error("parity enable differs from data enable");

  property p_write_floats;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !cmd.advance_or_load && selected && !cmd.write_enable_n) ##1 qual
      |=> !data_oe ##1 (!data_oe || !s_q.b_valid);
  endproperty
  a_write_floats: assert property (p_write_floats) // [RL3]
    else $error("driving during write data cycle");

  property p_deselect_floats;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !cmd.advance_or_load && !selected) ##1 qual |=> !data_oe;
  endproperty
  a_deselect_floats: assert property (p_deselect_floats) // [RL14]
    else $error("driving after deselect");

  property p_read_data;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && s_q.a_valid && !s_q.a_write)
      |=> data_out[7:0] == $past(rd_word[0][7:0]) && parity_lines_out[0] == $past(rd_word[0][8]);
  endproperty
  a_read_data: assert property (p_read_data) // [RL7]
    else $error("read data not from latched address");

  property p_burst_order;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && cmd.advance_or_load && s_q.order_s2)
      |=> s_q.a_addr[1:0] == ($past(s_q.a_base) ^ s_q.a_cnt);
  endproperty
  a_burst_order: assert property (p_burst_order) // [RL9]
    else $error("interleaved burst address wrong");

  // Reset must leave the lanes free for the controller
  property p_reset_floats;
    @(posedge core_clk)
    !rst_b |=> !data_oe && !parity_lines_oe && !s_q.drive_perm;
  endproperty
  a_reset_floats: assert property (p_reset_floats) // [RL3]
    else $error("driving right after reset");

  property p_read_gets_oe;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !cmd.advance_or_load && selected && cmd.write_enable_n)
      ##1 (qual && !s_q.allow_s2) |=> data_oe && parity_lines_oe;
  endproperty
  a_read_gets_oe: assert property (p_read_gets_oe) // [RL1] [RL12]
    else $error("allowed read not driven");

  property p_write_window_floats;
    @(posedge core_clk) disable iff (!rst_b)
    s_q.b_valid |-> !data_oe && !parity_lines_oe;
  endproperty
  a_write_window_floats: assert property (p_write_window_floats) // [RL3] [RL13]
    else $error("driving while write data pending");

  property p_emerge_floats;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !s_q.a_valid) |=> !data_oe;
  endproperty
  a_emerge_floats: assert property (p_emerge_floats) // [RL3]
    else $error("driving in first clock after deselect");

  property p_deselect_perm;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !cmd.advance_or_load && !selected) ##1 qual |=> !s_q.drive_perm;
  endproperty
  a_deselect_perm: assert property (p_deselect_perm) // [RL14]
    else $error("deselect kept drive permission");

  property p_burst_linear;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && cmd.advance_or_load && !s_q.order_s2)
      |=> s_q.a_addr[1:0] == 2'($past(s_q.a_base) + s_q.a_cnt);
  endproperty
  a_burst_linear: assert property (p_burst_linear) // [RL9]
    else $error("linear burst address wrong");

  property p_burst_keeps_type;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && cmd.advance_or_load)
      |=> $stable(s_q.a_valid) && $stable(s_q.a_write) &&
          $stable(s_q.a_addr[`PSDP_ADDR_W-1:2]);
  endproperty
  a_burst_keeps_type: assert property (p_burst_keeps_type) // [RL9]
    else $error("burst step changed access type");

  property p_load_takes;
    @(posedge core_clk) disable iff (!rst_b)
    (qual && !cmd.advance_or_load) |=> s_q.a_addr == $past(cmd.addr) &&
                                      s_q.a_valid == $past(selected);
  endproperty
  a_load_takes: assert property (p_load_takes) // [RL7]
    else $error("load did not latch address");

  property p_outputs_hold;
    @(posedge core_clk) disable iff (!rst_b)
    cycle_qualify_n |=> $stable(data_out) && $stable(parity_lines_out);
  endproperty
  a_outputs_hold: assert property (p_outputs_hold) // [RL5]
    else $error("read data moved on an unqualified edge");

  // A stall stretches a read; only the allow input may end the drive
  property p_stall_keeps_drive;
    @(posedge core_clk) disable iff (!rst_b)
    (cycle_qualify_n && s_q.drive_perm && !s_q.allow_s2) |=> data_oe;
  endproperty
  a_stall_keeps_drive: assert property (p_stall_keeps_drive) // [RL1] [RL5]
    else $error("stall dropped the drive");

  property p_allow_sync;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> s_q.allow_s2 == $past(s_q.allow_s1);
  endproperty
  a_allow_sync: assert property (p_allow_sync) // [RL2]
    else $error("allow input synchroniser skipped a stage");

  property p_strap_sync;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> s_q.order_s2 == $past(s_q.order_s1);
  endproperty
  a_strap_sync: assert property (p_strap_sync) // [RL10]
    else $error("strap synchroniser skipped a stage");

  c_read_out: cover property (@(posedge core_clk) disable iff (!rst_b) data_oe);
  c_write_done: cover property (@(posedge core_clk) disable iff (!rst_b)
    qual && s_q.b_valid);
  c_burst: cover property (@(posedge core_clk) disable iff (!rst_b)
    qual && cmd.advance_or_load && s_q.a_valid);
  c_stall: cover property (@(posedge core_clk) disable iff (!rst_b)
    cycle_qualify_n && s_q.drive_perm);
  c_deselect: cover property (@(posedge core_clk) disable iff (!rst_b)
    qual && !cmd.advance_or_load && !selected && s_q.drive_perm);

endmodule : psdp_port

// ==== inc/psdp_consts.svh ====
// Sizes and reset constants of the pipelined SRAM data port
`ifndef PSDP_CONSTS_SVH
`define PSDP_CONSTS_SVH
`define PSDP_ADDR_W 19
`define PSDP_LANES 4
`define PSDP_BYTE_W 8
`define PSDP_LANE_W 9
`define PSDP_DATA_W 32
`define PSDP_DEPTH 524288
`define PSDP_RST_ALLOW_N 1'h1
`define PSDP_RST_ORDER 1'h1
`endif

// ==== inc/psdp_pkg.sv ====
// Types of the pipelined SRAM data port
`include "psdp_consts.svh"
package psdp_pkg;

  typedef struct packed {
    logic select_one_n;
    logic select_two;
    logic select_three_n;
    logic write_enable_n;
    logic advance_or_load;
    logic [`PSDP_ADDR_W-1:0] addr;
    logic [`PSDP_LANES-1:0] lane_write_select_n;
  } psdp_cmd_type;

  typedef struct packed {
    logic allow_s1;
    logic allow_s2;
    logic order_s1;
    logic order_s2;
    logic a_valid;
    logic a_write;
    logic [`PSDP_ADDR_W-1:0] a_addr;
    logic [1:0] a_base;
    logic [1:0] a_cnt;
    logic [`PSDP_LANES-1:0] a_lane_wr_n;
    logic b_valid;
    logic [`PSDP_ADDR_W-1:0] b_addr;
    logic [`PSDP_LANES-1:0] b_lane_wr_n;
    logic drive_perm;
    logic [`PSDP_DATA_W-1:0] dout;
    logic [`PSDP_LANES-1:0] pout;
    logic data_oe;
    logic parity_oe;
  } psdp_state_type;

endpackage : psdp_pkg
